// ===== design/jbs_regs.svh
`ifndef JBS_REGS_SVH
`define JBS_REGS_SVH

// ----------------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------------
`define JBS_IR_LEN      10
`define JBS_IR_CAPT     10'h001
`define JBS_IR_EXTEST   10'h000
`define JBS_IR_SAMPLE   10'h005
`define JBS_IR_IDCODE   10'h006
`define JBS_IR_USERCODE 10'h007
`define JBS_IR_CONFIG   10'h002
`define JBS_IR_PROBE    10'h00E
`define JBS_IR_BYPASS   10'h3FF

// ----------------------------------------------------------------------
// Data register sizes and fixed fields
// ----------------------------------------------------------------------
`define JBS_WORD_LEN    32
`define JBS_ID_LSB      1'b1
`define JBS_BYTE_LEN    8
`define JBS_BIT_LAST    3'h7
`define JBS_BSR_LEN_DEF 420

`endif

// ===== design/jbs_pkg.sv
package jbs_pkg;

    // ------------------------------------------------------------------
    // Test access port controller states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        st_tlr, st_rti, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr,
        st_pau_dr, st_ex2_dr, st_upd_dr, st_sel_ir, st_cap_ir,
        st_sh_ir, st_ex1_ir, st_pau_ir, st_ex2_ir, st_upd_ir
    } jbs_tap_e;

    // ------------------------------------------------------------------
    // Data register placed between the serial input and output
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        sel_bypass, sel_idcode, sel_user, sel_bsr, sel_cfg, sel_probe
    } jbs_sel_e;

    // Standard sixteen-state walk on the mode select bit
    function automatic jbs_tap_e jbs_tap_next(input jbs_tap_e st,
                                              input logic     tms);
        case (st)
            st_tlr:    jbs_tap_next = tms ? st_tlr    : st_rti;
            st_rti:    jbs_tap_next = tms ? st_sel_dr : st_rti;
            st_sel_dr: jbs_tap_next = tms ? st_sel_ir : st_cap_dr;
            st_cap_dr: jbs_tap_next = tms ? st_ex1_dr : st_sh_dr;
            st_sh_dr:  jbs_tap_next = tms ? st_ex1_dr : st_sh_dr;
            st_ex1_dr: jbs_tap_next = tms ? st_upd_dr : st_pau_dr;
            st_pau_dr: jbs_tap_next = tms ? st_ex2_dr : st_pau_dr;
            st_ex2_dr: jbs_tap_next = tms ? st_upd_dr : st_sh_dr;
            st_upd_dr: jbs_tap_next = tms ? st_sel_dr : st_rti;
            st_sel_ir: jbs_tap_next = tms ? st_tlr    : st_cap_ir;
            st_cap_ir: jbs_tap_next = tms ? st_ex1_ir : st_sh_ir;
            st_sh_ir:  jbs_tap_next = tms ? st_ex1_ir : st_sh_ir;
            st_ex1_ir: jbs_tap_next = tms ? st_upd_ir : st_pau_ir;
            st_pau_ir: jbs_tap_next = tms ? st_ex2_ir : st_pau_ir;
            st_ex2_ir: jbs_tap_next = tms ? st_upd_ir : st_sh_ir;
            st_upd_ir: jbs_tap_next = tms ? st_sel_dr : st_rti;
            default:   jbs_tap_next = st_tlr;
        endcase
    endfunction

endpackage

// ===== design/jbs_buf2.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Two-entry buffer with valid/ready on both sides
// ----------------------------------------------------------------------
module jbs_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic      [W-1:0] out_data_out
);
    logic [W-1:0] d0_q, d0_d;   // Head entry, drives the output
    logic [W-1:0] d1_q, d1_d;   // Second entry
    logic [1:0]   cnt_q, cnt_d; // Number of entries held
    logic         push, pop;

    assign in_ready_out  = (cnt_q != 2'h2);
    assign out_valid_out = (cnt_q != 2'h0);
    assign out_data_out  = d0_q;
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // Next entries; a push with a pop from a single entry lands in the head entry
    always_comb begin
        d0_d  = d0_q;
        d1_d  = d1_q;
        cnt_d = cnt_q;
        if (pop) begin
            d0_d = d1_q;
        end
        if (push) begin
            if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
                d0_d = in_data_in;
            end else begin
                d1_d = in_data_in;
            end
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    // Registers only
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            d0_q  <= '0;
            d1_q  <= '0;
            cnt_q <= 2'h0;
        end else begin
            d0_q  <= d0_d;
            d1_q  <= d1_d;
            cnt_q <= cnt_d;
        end
    end

    hold_head_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        out_valid_out && !out_ready_in |=> out_valid_out
            && $stable(out_data_out))
        else $error("Buffer head changed while stalled");
endmodule

// ===== design/jbs_tap.sv
`timescale 1ns/1ps
`include "jbs_regs.svh"

// Operation
// - Boundary scan held off while configuring
// - Instruction register is ten bits
// - Usercode instruction shifts 32-bit user code
// - Bypass places one-bit register in path
// - Idcode instruction shifts identification value out
// - Id layout: version, part, maker, one
// - Sample captures pins, preloads pattern, harmless
// - Extest drives pattern, captures input pins
// - Configuration bytes load through scan path
// - Probe instruction reads internal signals serially
// - Boundary chain length is per-part parameter
// - No-scan variant: bypass and probe only
module jbs_tap #(
    parameter int          BSR_LEN   = `JBS_BSR_LEN_DEF,
    parameter int          N_PIN     = 8,
    parameter bit          HAS_BSCAN = 1'b1,
    parameter logic [3:0]  ID_VER    = 4'h1,    // Arbitrary value
    parameter logic [15:0] ID_PART   = 16'h1234, // Arbitrary value
    parameter logic [10:0] ID_MFR    = 11'h155,  // Arbitrary value
    parameter logic [31:0] USERCODE  = 32'hFFFFFFFF
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             tck_in,
    input  wire logic             tms_in,
    input  wire logic             tdi_in,
    output logic                  tdo_out,
    output logic                  tdo_oe_out,
    input  wire logic [N_PIN-1:0] pad_in,
    input  wire logic [N_PIN-1:0] core_pad_in,
    output logic      [N_PIN-1:0] pad_out,
    input  wire logic             cfg_busy_in,
    output logic      [7:0]       cfg_data_out,
    output logic                  cfg_valid_out,
    input  wire logic             cfg_ready_in,
    input  wire logic [30:0]      probe_in,
    output jbs_pkg::jbs_tap_e     tap_state_out
);
    import jbs_pkg::*;

    // ------------------------------------------------------------------
    // Crossings into the test clock domain
    // ------------------------------------------------------------------
    logic             rst_m_q, trst_n_q;   // Reset into test clock
    logic             busy_m_q, busy_s_q;  // Configuration busy level
    logic [N_PIN-1:0] pad_m_q, pad_s_q;    // Pin levels for capture
    logic             cack_m_q, cack_s_q;  // Byte taken acknowledge
    logic             pack_m_q, pack_s_q;  // Probe snapshot ready
    logic             cack_q, cack_d;      // Byte taken toggle, core side
    logic             pack_q, pack_d;      // Snapshot done toggle, core side
    logic [30:0]      snap_q, snap_d;      // Probe word, stable once acked
    // Two flops each; only the second stage is read
    always_ff @(posedge tck_in) begin
        rst_m_q  <= rst_n_in;
        trst_n_q <= rst_m_q;
        busy_m_q <= cfg_busy_in;
        busy_s_q <= busy_m_q;
        pad_m_q  <= pad_in;
        pad_s_q  <= pad_m_q;
        cack_m_q <= cack_q;
        cack_s_q <= cack_m_q;
        pack_m_q <= pack_q;
        pack_s_q <= pack_m_q;
    end
    // ------------------------------------------------------------------
    // Controller and instruction register
    // ------------------------------------------------------------------
    jbs_tap_e            st_q, st_d;
    logic [`JBS_IR_LEN-1:0] ir_sh_q, ir_sh_d; // Instruction shift stage
    logic [`JBS_IR_LEN-1:0] ir_q, ir_d;       // Active instruction
    jbs_sel_e            sel;
    logic                extest_act, sample_act;
    assign tap_state_out = st_q;
    // Picks the data register; boundary use waits for configuration
    function automatic jbs_sel_e decode(input logic [9:0] ir,
                                        input logic       busy);
        decode = sel_bypass;
        case (ir)
            `JBS_IR_PROBE:    decode = sel_probe;
            `JBS_IR_IDCODE:   if (HAS_BSCAN) decode = sel_idcode;
            `JBS_IR_USERCODE: if (HAS_BSCAN) decode = sel_user;
            `JBS_IR_CONFIG:   if (HAS_BSCAN) decode = sel_cfg;
            `JBS_IR_EXTEST,
            `JBS_IR_SAMPLE:   if (HAS_BSCAN && !busy) decode = sel_bsr;
            default:          decode = sel_bypass;
        endcase
    endfunction
    assign sel        = decode(ir_q, busy_s_q);
    assign extest_act = (sel == sel_bsr) && (ir_q == `JBS_IR_EXTEST);
    assign sample_act = (sel == sel_bsr) && (ir_q == `JBS_IR_SAMPLE);
    // Next controller state and instruction
    always_comb begin
        st_d    = jbs_tap_next(st_q, tms_in);
        ir_sh_d = ir_sh_q;
        ir_d    = ir_q;
        case (st_q)
            st_tlr:    ir_d    = `JBS_IR_IDCODE;
            st_cap_ir: ir_sh_d = `JBS_IR_CAPT;
            st_sh_ir:  ir_sh_d = {tdi_in, ir_sh_q[`JBS_IR_LEN-1:1]};
            st_upd_ir: ir_d    = ir_sh_q;
            default:   ir_sh_d = ir_sh_q;
        endcase
    end
    // Registers only
    always_ff @(posedge tck_in) begin
        if (!trst_n_q) begin
            st_q    <= st_tlr;
            ir_sh_q <= `JBS_IR_CAPT;
            ir_q    <= `JBS_IR_IDCODE;
        end else begin
            st_q    <= st_d;
            ir_sh_q <= ir_sh_d;
            ir_q    <= ir_d;
        end
    end
    // ------------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------------
    logic                   byp_q, byp_d;       // Bypass stage
    logic [31:0]            w32_q, w32_d;       // Id, user code, probe
    logic [BSR_LEN-1:0]     bsr_q, bsr_d;       // Boundary shift chain
    logic [N_PIN-1:0]       upd_q, upd_d;       // Boundary update stage
    logic [7:0]             csh_q, csh_d;       // Config byte assembly
    logic [2:0]             cbit_q, cbit_d;     // Bits of current byte
    logic [7:0]             chold_q, chold_d;   // Byte handed to core
    logic                   creq_q, creq_d;     // Byte offered toggle
    logic                   preq_q, preq_d;     // Snapshot request toggle
    logic                   cpend;
    // A byte is pending until the core side echoes the toggle; bytes
    // finished meanwhile are dropped, since the tester cannot be held
    assign cpend = (creq_q != cack_s_q);
    // Next data register values
    always_comb begin
        byp_d   = byp_q;
        w32_d   = w32_q;
        bsr_d   = bsr_q;
        upd_d   = upd_q;
        csh_d   = csh_q;
        cbit_d  = cbit_q;
        chold_d = chold_q;
        creq_d  = creq_q;
        preq_d  = preq_q;
        case (st_q)
            st_cap_dr: begin
                byp_d  = 1'b0;
                cbit_d = 3'h0;
                case (sel)
                    sel_idcode: w32_d = {ID_VER, ID_PART, ID_MFR,
                                         `JBS_ID_LSB};
                    sel_user:   w32_d = USERCODE;
                    sel_probe:  w32_d = {preq_q == pack_s_q,
                                         snap_q};
                    sel_bsr: begin
                        for (int i = 0; i < N_PIN && i < BSR_LEN;
                             i++) begin
                            bsr_d[i] = pad_s_q[i];
                        end
                    end
                    default: w32_d = w32_q;
                endcase
            end
            st_sh_dr: begin
                case (sel)
                    sel_bypass: byp_d = tdi_in;
                    sel_bsr: begin
                        bsr_d          = bsr_q >> 1;
                        bsr_d[BSR_LEN-1] = tdi_in;
                    end
                    sel_cfg: begin
                        csh_d  = {tdi_in, csh_q[7:1]};
                        cbit_d = cbit_q + 3'h1;
                        if (cbit_q == `JBS_BIT_LAST && !cpend) begin
                            chold_d = {tdi_in, csh_q[7:1]};
                            creq_d  = ~creq_q;
                        end
                    end
                    default: w32_d = {tdi_in, w32_q[31:1]};
                endcase
            end
            st_upd_dr: begin
                if (sel == sel_bsr) begin
                    for (int i = 0; i < N_PIN && i < BSR_LEN; i++) begin
                        upd_d[i] = bsr_q[i];
                    end
                end
                if (sel == sel_probe) begin
                    preq_d = ~preq_q;
                end
            end
            default: byp_d = byp_q;
        endcase
    end
    // Registers only
    always_ff @(posedge tck_in) begin
        if (!trst_n_q) begin
            byp_q   <= 1'b0;
            w32_q   <= '0;
            bsr_q   <= '0;
            upd_q   <= '0;
            csh_q   <= 8'h00;
            cbit_q  <= 3'h0;
            chold_q <= 8'h00;
            creq_q  <= 1'b0;
            preq_q  <= 1'b0;
        end else begin
            byp_q   <= byp_d;
            w32_q   <= w32_d;
            bsr_q   <= bsr_d;
            upd_q   <= upd_d;
            csh_q   <= csh_d;
            cbit_q  <= cbit_d;
            chold_q <= chold_d;
            creq_q  <= creq_d;
            preq_q  <= preq_d;
        end
    end
    // Pins follow the core except while the test pattern is driven
    assign pad_out = extest_act ? upd_q : core_pad_in;

    // ------------------------------------------------------------------
    // Serial output, moved on the falling edge
    // ------------------------------------------------------------------
    logic tdo_d, oe_d, tdo_q, oe_q; // Next and registered output
    // Output bit of whatever sits in the path
    always_comb begin
        oe_d = (st_q == st_sh_dr) || (st_q == st_sh_ir);
        case (sel)
            sel_bypass: tdo_d = byp_q;
            sel_bsr:    tdo_d = bsr_q[0];
            sel_cfg:    tdo_d = csh_q[0];
            default:    tdo_d = w32_q[0];
        endcase
        if (st_q == st_sh_ir) begin
            tdo_d = ir_sh_q[0];
        end
    end
    // Falling edge gives the far end half a period of setup
    always_ff @(negedge tck_in) begin
        if (!trst_n_q) begin
            tdo_q <= 1'b0;
            oe_q  <= 1'b0;
        end else begin
            tdo_q <= tdo_d;
            oe_q  <= oe_d;
        end
    end
    assign tdo_out    = tdo_q;
    assign tdo_oe_out = oe_q;
    // ------------------------------------------------------------------
    // Core clock side: byte and snapshot handshakes
    // ------------------------------------------------------------------
    logic        creq_m_q, creq_s_q;  // Byte offered, synchronised
    logic        preq_m_q, preq_s_q;  // Snapshot request, synchronised
    logic        buf_ready, cpush;
    // Two flops each into the core clock
    always_ff @(posedge core_clk_in) begin
        creq_m_q <= creq_q;
        creq_s_q <= creq_m_q;
        preq_m_q <= preq_q;
        preq_s_q <= preq_m_q;
    end
    // Taking a byte waits for room, so a stalled reader loses no byte already offered
    assign cpush = (creq_s_q != cack_q) && buf_ready;
    // Next handshake state
    always_comb begin
        cack_d = cpush ? creq_s_q : cack_q;
        pack_d = preq_s_q;
        snap_d = (preq_s_q != pack_q) ? probe_in : snap_q;
    end
    // Registers only
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            cack_q <= 1'b0;
            pack_q <= 1'b0;
            snap_q <= '0;
        end else begin
            cack_q <= cack_d;
            pack_q <= pack_d;
            snap_q <= snap_d;
        end
    end
    jbs_buf2 #(
        .W (`JBS_BYTE_LEN)
    ) u_cfg_buf (
        .clk_in        (core_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (creq_s_q != cack_q),
        .in_ready_out  (buf_ready),
        .in_data_in    (chold_q),
        .out_valid_out (cfg_valid_out),
        .out_ready_in  (cfg_ready_in),
        .out_data_out  (cfg_data_out)
    );
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    ir_load_a: assert property (@(posedge tck_in) disable iff (!trst_n_q)
        st_q == st_upd_ir |=> ir_q == $past(ir_sh_q))
        else $error("Instruction not loaded at update");
    bypass_a: assert property (@(posedge tck_in) disable iff (!trst_n_q)
        st_q == st_sh_dr && sel == sel_bypass |=> byp_q == $past(tdi_in))
        else $error("Bypass stage lost data");
    reset_id_a: assert property (@(posedge tck_in) disable iff (!trst_n_q)
        st_q == st_tlr |=> ir_q == `JBS_IR_IDCODE)
        else $error("Idcode not selected after logic reset");
    id_layout_a: assert property (@(posedge tck_in) disable iff (!trst_n_q)
        st_q == st_cap_dr && sel == sel_idcode |=>
            w32_q == {ID_VER, ID_PART, ID_MFR, 1'b1})
        else $error("Identification word wrong");
    user_code_a: assert property (@(posedge tck_in) disable iff (!trst_n_q)
        st_q == st_cap_dr && sel == sel_user |=> w32_q == USERCODE)
        else $error("User code not captured");
    sample_pins_a: assert property (@(posedge tck_in) disable iff (!trst_n_q)
        sample_act |-> pad_out == core_pad_in)
        else $error("Sample disturbed the pins");
    extest_drive_a: assert property (@(posedge tck_in)
        disable iff (!trst_n_q) extest_act |-> pad_out == upd_q)
        else $error("Extest pattern not on pins");
    busy_hold_a: assert property (@(posedge tck_in) disable iff (!trst_n_q)
        busy_s_q |-> sel != sel_bsr && !extest_act)
        else $error("Boundary scan ran while configuring");
    no_scan_a: assert property (@(posedge tck_in) disable iff (!trst_n_q)
        !HAS_BSCAN |-> sel == sel_bypass || sel == sel_probe)
        else $error("Variant without scan chose another path");
    tdo_enable_a: assert property (@(negedge tck_in)
        disable iff (!trst_n_q)
        st_q == st_sh_dr || st_q == st_sh_ir |=> tdo_oe_out)
        else $error("Output not enabled during shift");
    probe_snap_a: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        preq_s_q != pack_q |=> snap_q == $past(probe_in))
        else $error("Probe snapshot not taken");
endmodule

// ===== verification/jbs_ctl_model.sv
`timescale 1ns/1ps

// ------------------------------------------------
// Scan controller model; test clock idles low
// ------------------------------------------------
module jbs_ctl_model (
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out,
    input  wire logic tdo_in
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end

    // One period: drive after fall, sample output at rise
    task automatic tk(input logic m, input logic d, output logic o);
        tms_out = m;
        tdi_out = d;
        #6 tck_out = 1'b1;
        o = tdo_in;
        #6 tck_out = 1'b0;
    endtask

    // Idle clocks; data line keeps toggling, nobody reads it
    task automatic idle(input int n, input logic m);
        logic o;
        for (int i = 0; i < n; i++) tk(m, ~tdi_out, o);
    endtask

    // Idle to idle scan, instruction path when ir is set
    task automatic scan(input bit ir, input int n,
                        input logic [511:0] d, output logic [511:0] q);
        logic o;
        q = '0;
        tk(1'b1, 1'b0, o);
        if (ir) tk(1'b1, 1'b0, o);
        tk(1'b0, 1'b0, o);
        tk(1'b0, 1'b0, o);
        // Exactly n bits every scan, last bit leaves shift
        for (int i = 0; i < n; i++) begin
            tk(i == n - 1, d[i], o);
            q[i] = o;
        end
        tk(1'b1, 1'b0, o);
        tk(1'b0, ~d[n-1], o);
    endtask
endmodule

// ===== verification/jtag_boundary_scan_port_tb.sv
`timescale 1ns/1ps
`include "jbs_regs.svh"

module jtag_boundary_scan_port_tb;
    import jbs_pkg::*;
    localparam int          BL = 420;          // Chain length of this part
    localparam logic [31:0] ID = 32'h25A3C56F; // Arbitrary, lsb one
    localparam logic [31:0] UC = 32'h6D2E91C4; // Arbitrary user code
    logic core_clk_in, rst_n_in, tck, tms, tdi, tdo_out, tdo_oe_out;
    logic [7:0]   pad_in, core_pad_in, pad_out, cfg_data_out, pv;
    logic         cfg_busy_in, cfg_valid_out, cfg_ready_in, stall;
    logic [30:0]  probe_in;
    logic [9:0]   code;
    logic [511:0] din, dout;
    jbs_tap_e     tap_state_out;
    logic [7:0]   cfg_q[$];       // Bytes still owed by the buffer
    int           num_errors, comparisons;

    jbs_tap #(.BSR_LEN(BL), .ID_VER(ID[31:28]), .ID_PART(ID[27:12]),
              .ID_MFR(ID[11:1]), .USERCODE(UC)) uut (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .tck_in(tck),
        .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo_out),
        .tdo_oe_out(tdo_oe_out), .pad_in(pad_in),
        .core_pad_in(core_pad_in), .pad_out(pad_out),
        .cfg_busy_in(cfg_busy_in), .cfg_data_out(cfg_data_out),
        .cfg_valid_out(cfg_valid_out), .cfg_ready_in(cfg_ready_in),
        .probe_in(probe_in), .tap_state_out(tap_state_out));
    jbs_ctl_model jm (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
                      .tdo_in(tdo_out));

    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    // Receiver stalls on request, else accepts at random
    always @(negedge core_clk_in) begin
        cfg_ready_in <= stall ? 1'b0 : 1'($urandom);
    end

    // Every accepted byte must be the next one owed
    always @(posedge core_clk_in) begin
        if (rst_n_in && cfg_valid_out === 1'b1 && cfg_ready_in === 1'b1)
            chk(32'(cfg_data_out),
                cfg_q.size() ? 32'(cfg_q.pop_front()) : 32'hX);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what = "config byte");
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %0h exp %0h",
                     $time, what, got, exp);
        end
    endtask

    // Scan, then the port must sit idle with output released
    task automatic scan(input bit ir, input int n, input logic [511:0] d);
        jm.scan(ir, n, d, dout);
        chk({27'h0, tdo_oe_out, tap_state_out}, {28'h0, st_rti}, "idle");
    endtask

    task automatic load(input logic [9:0] c);
        scan(1'b1, `JBS_IR_LEN, {502'h0, c});
        chk(32'(dout[9:0]), 32'(`JBS_IR_CAPT), "ir capture");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Whole run is near 16 us; give it ample margin
    initial begin
        #500000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h1942));
        {pad_in, core_pad_in, probe_in, cfg_busy_in} = '0;
        {rst_n_in, stall} = 2'h1;
        fork
            begin
                repeat (3) @(negedge core_clk_in);
                rst_n_in = 1'b1;
            end
            jm.idle(4, 1'b1);
        join
        jm.idle(6, 1'b1);
        jm.idle(1, 1'b0);
        scan(1'b0, 32, '0);
        chk(dout[31:0], ID, "idcode");
        load(`JBS_IR_USERCODE);
        scan(1'b0, 32, '0);
        chk(dout[31:0], UC, "usercode");
        $display("test ident finished");
        // Bypass, and an unassigned code that must act the same
        for (int k = 0; k < 2; k++) begin
            code = k ? (10'h100 | 10'($urandom & 32'hF0)) : `JBS_IR_BYPASS;
            load(code);
            din = 512'($urandom);
            scan(1'b0, 8, din);
            chk(32'(dout[7:0]), 32'({din[6:0], 1'b0}), "bypass");
        end
        // Boundary access while configuring reads as bypass
        @(negedge core_clk_in);
        cfg_busy_in = 1'b1;
        load(`JBS_IR_SAMPLE);
        scan(1'b0, 8, din);
        chk(32'(dout[7:0]), 32'({din[6:0], 1'b0}), "busy");
        @(negedge core_clk_in);
        cfg_busy_in = 1'b0;
        pad_in = 8'($urandom);
        core_pad_in = 8'($urandom);
        pv = pad_in;
        $display("test bypass finished");
        load(`JBS_IR_SAMPLE);
        din = 512'({$urandom, $urandom});
        scan(1'b0, BL + 8, din);
        chk(32'(dout[7:0]), 32'(pv), "sample");
        chk(32'(dout[BL+:8]), 32'(din[7:0]), "chain length");
        chk(32'(pad_out), 32'(core_pad_in), "undisturbed");
        @(negedge core_clk_in);
        pad_in = ~pv;
        load(`JBS_IR_EXTEST);
        chk(32'(pad_out), 32'(din[15:8]), "preload");
        din = 512'({$urandom, $urandom});
        scan(1'b0, BL + 8, din);
        chk(32'(dout[7:0]), {24'h0, ~pv}, "extest capture");
        chk(32'(pad_out), 32'(din[15:8]), "extest drive");
        jm.idle(5, 1'b1);
        jm.idle(1, 1'b0);
        chk(32'(pad_out), 32'(core_pad_in), "after reset");
        $display("test boundary finished");
        // Two whole bytes and a stray nibble, receiver stalled
        load(`JBS_IR_CONFIG);
        din = 512'($urandom);
        cfg_q.push_back(din[7:0]);
        cfg_q.push_back(din[15:8]);
        // One byte per scan: a byte finished while the last is still
        // unacknowledged is dropped, and bits come faster than the echo
        scan(1'b0, 8, din);
        repeat (10) @(negedge core_clk_in);
        scan(1'b0, 12, din >> 8);
        repeat (10) @(negedge core_clk_in);
        chk(32'(cfg_valid_out), 32'h1, "held");
        stall = 1'b0;
        for (int i = 0; i < 200 && cfg_q.size() != 0; i++)
            @(negedge core_clk_in);
        repeat (20) @(negedge core_clk_in);
        chk(32'(cfg_q.size()), 32'h0, "bytes owed");
        stall = 1'b1;
        $display("test config finished");
        probe_in = 31'($urandom);
        load(`JBS_IR_PROBE);
        scan(1'b0, 32, '0);
        repeat (10) @(negedge core_clk_in);
        jm.idle(4, 1'b0);
        scan(1'b0, 32, '0);
        chk(dout[31:0], {1'b1, probe_in}, "probe word");
        $display("test probe finished");
        tally_and_finish();
    end
endmodule
